//--- hw/dom_timer.sv
// Level duration timer restarted whenever the watched level drops
`timescale 1ns/1ps
`default_nettype none
module dom_timer #(
    parameter int LIMIT = 16
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Level
    input  wire logic active,
    output var  logic expired
);
    localparam int W = $clog2(LIMIT + 1);
    localparam logic [W-1:0] LIM = W'(LIMIT);
    logic [W-1:0] count;

    if (LIMIT < 1)
    begin : g_chk
        $error("dom_timer LIMIT must be at least one");
    end

    // Saturating so a held level keeps the expiry asserted
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            count <= '0;
        else if (!active)
            count <= '0;
        else if (count != LIM)
            count <= count + W'(1);
    end

    assign expired = active && (count == LIM);
endmodule
`default_nettype wire

//--- hw/event_fifo.sv
// Event record FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module event_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Fill side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output var  logic         in_ready,
    // Drain side
    output var  logic         out_valid,
    output var  logic [W-1:0] out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          push;
    logic          pop;

    if (DEPTH < 2)
    begin : g_chk
        $error("event_fifo DEPTH must be at least two");
    end

    assign in_ready  = cnt != FULL;
    assign out_valid = cnt != '0;
    assign out_data  = mem[rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wp] <= in_data;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end
        else
        begin
            if (push)
                wp <= (wp == LAST) ? '0 : wp + AW'(1);
            if (pop)
                rp <= (rp == LAST) ? '0 : rp + AW'(1);
            if (push && !pop)
                cnt <= cnt + (AW + 1)'(1);
            else if (pop && !push)
                cnt <= cnt - (AW + 1)'(1);
        end
    end
endmodule
`default_nettype wire

//--- hw/lin_xcvr_ctrl.sv
// Bus transceiver mode, enabling, wake and fault control
`timescale 1ns/1ps
`default_nettype none
`include "lin_xcvr_regs.svh"
module lin_xcvr_ctrl #(
    parameter int EN_CYCLES     = 1250,
    parameter int TXD_TO_CYCLES = 1250000,
    parameter int BUS_TO_CYCLES = 1250000
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    // System state
    input  wire lin_xcvr_pkg::sys_mode_t sys_mode,
    input  wire logic                    watchdog_enabled,
    input  wire logic                    watchdog_on_bus_wake,
    // Serial configuration
    input  wire logic                    mode_wr,
    input  wire lin_xcvr_pkg::xcvr_mode_t mode_req,
    input  wire logic                    cfg_wr,
    input  wire logic                    low_slope_in,
    input  wire logic                    flash_in,
    input  wire logic                    serial_select_n,
    input  wire logic                    fail_clear,
    input  wire logic                    wake_clear,
    // Pins
    input  wire logic                    bus_level_in,
    output var  logic                    bus_drive_out,
    output var  logic                    bus_drive_oe,
    input  wire logic                    bus_transmit_input,
    output var  logic                    rxd_out,
    input  wire logic                    supply_uv,
    // Status
    output var  lin_xcvr_pkg::xcvr_mode_t first_transceiver_mode_field,
    output var  logic                    first_transceiver_fail_flag,
    output var  logic                    bus_wake_flag,
    output var  logic                    int_n,
    output var  logic                    restart_req,
    output var  logic                    main_supply_ramp,
    output var  logic                    watchdog_enable_req,
    output var  logic                    low_slope_select,
    output var  logic                    slope_off,
    // Event records
    output var  logic                    ev_valid,
    output var  logic [6:0]              ev_data,
    input  wire logic                    ev_ready
);
    import lin_xcvr_pkg::*;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    localparam int NP = 4;
    localparam logic [NP-1:0] PIN_RST = `PIN_RST;
    logic [NP-1:0] pin_raw;
    logic [NP-1:0] pin_s;

    if (EN_CYCLES < 1 || TXD_TO_CYCLES < 1 || BUS_TO_CYCLES < 1)
    begin : g_chk_t
        $error("lin_xcvr_ctrl timing counts must be positive");
    end
    if (`WAKE_FILTER_CYC > `WAKE_FILTER_MAX_CYC)
    begin : g_chk_w
        $error("lin_xcvr_ctrl wake filter exceeds its limit");
    end

    assign pin_raw = {serial_select_n, supply_uv,
                      bus_transmit_input, bus_level_in};

    // A change counts only once the second and third stage agree
    for (genvar i = 0; i < NP; i++)
    begin : g_sync
        logic [2:0] sh;
        logic       st;
        always_ff @(posedge clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                sh <= {3{PIN_RST[i]}};
                st <= PIN_RST[i];
            end
            else
            begin
                sh <= {sh[1:0], pin_raw[i]};
                if (sh[1] == sh[2])
                    st <= sh[2];
            end
        end
        assign pin_s[i] = st;
    end

    logic bus_dom;
    logic txd_dom;
    logic uv;
    logic ssn;
    assign bus_dom = !pin_s[`PIN_BUS];
    assign txd_dom = !pin_s[`PIN_TXD];
    assign uv      = pin_s[`PIN_UV];
    assign ssn     = pin_s[`PIN_SSN];

    // ************************************************************
    // System mode tracking
    // ************************************************************
    sys_mode_t sys_prev;
    logic      sys_chg;
    logic      rearm_sys;
    logic      sys_run;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            sys_prev <= SYS_NORMAL;
        else
            sys_prev <= sys_mode;
    end

    assign sys_chg   = sys_mode != sys_prev;
    assign sys_run   = sys_mode == SYS_NORMAL || sys_mode == SYS_STOP;
    assign rearm_sys = sys_chg && (sys_mode == SYS_STOP ||
                       sys_mode == SYS_SLEEP || sys_mode == SYS_FAILSAFE);

    // ************************************************************
    // Transceiver mode
    // ************************************************************
    xcvr_mode_t mode;
    logic       m_norm;
    logic       m_rx;

    assign m_norm = mode == XM_NORMAL;
    assign m_rx   = mode == XM_RXONLY;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            mode <= XM_OFF;
        else if (sys_chg && sys_mode == SYS_FAILSAFE)
            mode <= XM_WAKE;
        else if (mode_wr)
        begin
            unique case (mode_req)
                XM_OFF:    mode <= XM_OFF;
                XM_WAKE:   mode <= XM_WAKE;
                XM_RXONLY,
                XM_NORMAL:
                begin
                    if (sys_mode == SYS_NORMAL)
                        mode <= mode_req;
                end
            endcase
        end
        else if (!sys_run && (m_norm || m_rx))
            mode <= XM_WAKE;
    end

    // ************************************************************
    // Wake detection
    // ************************************************************
    wake_state_t wk;
    logic        wf_exp;
    logic        wake_fire;
    logic        ev_pend;

    dom_timer #(
        .LIMIT (`WAKE_FILTER_CYC)
    ) u_wake_filt (
        .clk     (clk),
        .rst_b   (rst_b),
        .active  (wk == WK_DOM && bus_dom),
        .expired (wf_exp)
    );

    // A full event queue holds the wake back rather than losing it
    assign wake_fire = wk == WK_LONG && !bus_dom && !ev_pend;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            wk <= WK_WAIT;
        else if (mode != XM_WAKE || rearm_sys)
            wk <= WK_WAIT;
        else
        begin
            unique case (wk)
                WK_WAIT: if (!bus_dom) wk <= WK_REC;
                WK_REC:  if (bus_dom) wk <= WK_DOM;
                WK_DOM:
                begin
                    if (!bus_dom)
                        wk <= WK_REC;
                    else if (wf_exp)
                        wk <= WK_LONG;
                end
                WK_LONG: if (wake_fire) wk <= WK_DONE;
                WK_DONE: wk <= WK_DONE;
            endcase
        end
    end

    // ************************************************************
    // Wake consequences
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bus_wake_flag       <= 1'b0;
            int_n               <= 1'b1;
            restart_req         <= 1'b0;
            main_supply_ramp    <= 1'b0;
            watchdog_enable_req <= 1'b0;
        end
        else
        begin
            if (wake_fire)
                bus_wake_flag <= 1'b1;
            else if (wake_clear)
                bus_wake_flag <= 1'b0;
            if (wake_fire && sys_run)
                int_n <= 1'b0;
            else if (wake_clear)
                int_n <= 1'b1;
            restart_req <= wake_fire && !sys_run;
            main_supply_ramp <= wake_fire && (sys_mode == SYS_SLEEP ||
                                sys_mode == SYS_FAILSAFE);
            watchdog_enable_req <= wake_fire && sys_mode == SYS_STOP &&
                                   watchdog_on_bus_wake &&
                                   !watchdog_enabled;
        end
    end

    // ************************************************************
    // Enabling and transmit path
    // ************************************************************
    logic en_done;
    logic tx_arm;
    logic txd_to;
    logic bus_to;

    dom_timer #(
        .LIMIT (EN_CYCLES)
    ) u_enable (
        .clk     (clk),
        .rst_b   (rst_b),
        .active  (m_norm),
        .expired (en_done)
    );

    dom_timer #(
        .LIMIT (TXD_TO_CYCLES)
    ) u_txd_to (
        .clk     (clk),
        .rst_b   (rst_b),
        .active  (txd_dom),
        .expired (txd_to)
    );

    dom_timer #(
        .LIMIT (BUS_TO_CYCLES)
    ) u_bus_to (
        .clk     (clk),
        .rst_b   (rst_b),
        .active  (bus_dom && (m_norm || m_rx)),
        .expired (bus_to)
    );

    // A low already present at the end of enabling is never sent
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            tx_arm <= 1'b0;
        else if (!m_norm)
            tx_arm <= 1'b0;
        else if (en_done && !txd_dom)
            tx_arm <= 1'b1;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bus_drive_out <= 1'b0;
            bus_drive_oe  <= 1'b0;
            rxd_out       <= 1'b1;
        end
        else
        begin
            bus_drive_out <= 1'b0;
            bus_drive_oe  <= m_norm && tx_arm && txd_dom &&
                             !txd_to && !uv;
            if (m_norm || m_rx)
                rxd_out <= uv || !bus_dom;
            else
                rxd_out <= !(mode == XM_WAKE && wk == WK_DONE);
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            first_transceiver_fail_flag <= 1'b0;
        else if ((txd_to && m_norm) || bus_to)
            first_transceiver_fail_flag <= 1'b1;
        else if (fail_clear)
            first_transceiver_fail_flag <= 1'b0;
    end

    assign first_transceiver_mode_field = mode;

    // ************************************************************
    // Slope selection
    // ************************************************************
    logic pend_low;
    logic pend_flash;
    logic ssn_prev;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pend_low         <= `SLOPE_LOW_RST;
            pend_flash       <= `SLOPE_OFF_RST;
            ssn_prev         <= 1'b1;
            low_slope_select <= `SLOPE_LOW_RST;
            slope_off        <= `SLOPE_OFF_RST;
        end
        else
        begin
            ssn_prev <= ssn;
            if (cfg_wr && sys_mode == SYS_NORMAL)
            begin
                pend_low   <= low_slope_in;
                pend_flash <= flash_in;
            end
            if (ssn && !ssn_prev)
            begin
                low_slope_select <= pend_low;
                slope_off        <= pend_flash;
            end
        end
    end

    // ************************************************************
    // Event records
    // ************************************************************
    logic [6:0] ev_word;
    logic       ev_in_ready;
    logic       fail_prev;
    logic       to_rise;

    assign to_rise = (txd_to && m_norm) && !fail_prev;

    // Fault events arriving while one waits are dropped, not queued
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ev_pend   <= 1'b0;
            ev_word   <= '0;
            fail_prev <= 1'b0;
        end
        else
        begin
            fail_prev <= (txd_to && m_norm) || bus_to;
            if (ev_pend && ev_in_ready)
                ev_pend <= 1'b0;
            else if (wake_fire)
            begin
                ev_pend <= 1'b1;
                ev_word <= {`EV_WAKE, sys_mode};
            end
            else if (!ev_pend && (to_rise || (bus_to && !fail_prev)))
            begin
                ev_pend <= 1'b1;
                ev_word <= {to_rise ? `EV_TX_TIMEOUT : `EV_CLAMP,
                            sys_mode};
            end
        end
    end

    event_fifo #(
        .W     (7),
        .DEPTH (`EV_FIFO_DEPTH)
    ) u_events (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (ev_pend),
        .in_data   (ev_word),
        .in_ready  (ev_in_ready),
        .out_valid (ev_valid),
        .out_data  (ev_data),
        .out_ready (ev_ready)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_woken;
        wake_fire ##1 (mode == XM_WAKE && !rearm_sys);
    endsequence
    sequence s_slope_try;
        cfg_wr && sys_mode != SYS_NORMAL;
    endsequence
    sequence s_select_rise;
        ssn && !ssn_prev;
    endsequence

    chk_off_select: assert property (mode_wr && mode_req == XM_OFF &&
        !(sys_chg && sys_mode == SYS_FAILSAFE) |=> mode == XM_OFF)
        else $error("off request not taken");
    chk_off_deaf: assert property (mode == XM_OFF |-> !wake_fire)
        else $error("wake fired in off mode");
    chk_normal_gate: assert property (mode_wr && mode_req == XM_NORMAL &&
        sys_mode == SYS_STOP && !sys_chg |=> $stable(mode))
        else $error("normal mode taken outside system Normal");
    chk_drive_src: assert property (bus_drive_oe |->
        $past(txd_dom) && $past(tx_arm) && $past(en_done) || $past(tx_arm))
        else $error("bus driven before enabling completed");
    chk_rx_quiet: assert property (m_rx |=> !bus_drive_oe)
        else $error("driver active in receive-only");
    chk_fs_wake: assert property (sys_chg && sys_mode == SYS_FAILSAFE
        |=> mode == XM_WAKE)
        else $error("fail-safe entry did not select wake mode");
    chk_wake_rxd: assert property (s_woken |=> !rxd_out)
        else $error("receive output not held low after wake");
    chk_int_wake: assert property (wake_fire && sys_run
        |=> !int_n && bus_wake_flag && !restart_req)
        else $error("run-mode wake not signalled");
    chk_sleep_wake: assert property (wake_fire && sys_mode == SYS_SLEEP
        |=> restart_req && main_supply_ramp && int_n == $past(int_n))
        else $error("sleep wake misreported");
    chk_txd_cut: assert property (txd_to |=> !bus_drive_oe)
        else $error("driver active after transmit time-out");
    chk_uv_off: assert property (uv && m_norm |=> !bus_drive_oe && rxd_out)
        else $error("stages active in undervoltage");
    chk_slope_hold: assert property (s_slope_try |=> $stable(pend_low))
        else $error("slope changed by write outside Normal");
    chk_slope_apply: assert property (s_select_rise
        |=> low_slope_select == $past(pend_low))
        else $error("slope not applied on select release");
endmodule
`default_nettype wire

//--- hw/lin_xcvr_pkg.sv
// Types shared by the bus transceiver control block
package lin_xcvr_pkg;
    typedef enum logic [4:0] {
        SYS_NORMAL   = 5'h01,
        SYS_STOP     = 5'h02,
        SYS_SLEEP    = 5'h04,
        SYS_RESTART  = 5'h08,
        SYS_FAILSAFE = 5'h10
    } sys_mode_t;
    typedef enum logic [1:0] {
        XM_OFF    = 2'h0,
        XM_WAKE   = 2'h1,
        XM_RXONLY = 2'h2,
        XM_NORMAL = 2'h3
    } xcvr_mode_t;
    typedef enum logic [4:0] {
        WK_WAIT = 5'h01,
        WK_REC  = 5'h02,
        WK_DOM  = 5'h04,
        WK_LONG = 5'h08,
        WK_DONE = 5'h10
    } wake_state_t;
endpackage

//--- hw/lin_xcvr_regs.svh
// Constants for the bus transceiver mode and wake control block
`ifndef LIN_XCVR_REGS_SVH
`define LIN_XCVR_REGS_SVH

`define CLK_PERIOD_NS      8
`define WAKE_FILTER_US     30
`define WAKE_FILTER_MAX_US 150
`define WAKE_FILTER_CYC \
    ((`WAKE_FILTER_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_FILTER_MAX_CYC \
    ((`WAKE_FILTER_MAX_US * 1000) / `CLK_PERIOD_NS)

`define SLOPE_LOW_RST      1'b0
`define SLOPE_OFF_RST      1'b0
`define PIN_RST            4'hb
`define PIN_BUS            0
`define PIN_TXD            1
`define PIN_UV             2
`define PIN_SSN            3

`define EV_WAKE            2'h1
`define EV_TX_TIMEOUT      2'h2
`define EV_CLAMP           2'h3
`define EV_FIFO_DEPTH      32

`endif

//--- tb/lin_remote_node.sv
// Far-side bus node and wire resolution for the transceiver bench
`timescale 1ns/1ps
`default_nettype none
module lin_remote_node (
    // Wire parties
    input  wire logic dut_oe,
    input  wire logic remote_dom,
    // Resolved level
    output var  logic bus_level
);
    // Pull-up: wire sits recessive when nobody pulls it down
    always_comb bus_level = !(dut_oe || remote_dom);
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the transceiver mode and wake control
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lin_xcvr_pkg::*;
    logic       clk = 0, rst_b = 0, mode_wr = 0, cfg_wr = 0, ssn = 1;
    logic       wd_on = 0, low_in = 0, fclr = 0, wclr = 0, txd = 1;
    logic       rdom = 0, ev_rdy = 1, sclr = 0, bus, oe, dout, rxd;
    logic       uv_in = 0, flash = 0, wd_en = 0;
    logic       fail, wkf, int_n, rst_q, ramp, wd_q, low_q, soff, ev_v;
    logic [6:0] ev_d;
    logic [2:0] seen;
    sys_mode_t  sys = SYS_NORMAL;
    xcvr_mode_t mreq = XM_OFF, mode_f;
    int         n_mismatch = 0, n_tests = 0;
    always #4 clk = ~clk;
    // Pulses last one cycle, so keep them until the bench asks
    always @(posedge clk)
        seen <= sclr ? 3'h0 : seen | {rst_q, ramp, wd_q};
    lin_remote_node u_far (.dut_oe(oe), .remote_dom(rdom), .bus_level(bus));
    lin_xcvr_ctrl #(.EN_CYCLES(8), .TXD_TO_CYCLES(20), .BUS_TO_CYCLES(20))
    u_dut (.clk(clk), .rst_b(rst_b), .sys_mode(sys),
        .watchdog_enabled(wd_en), .watchdog_on_bus_wake(wd_on),
        .mode_wr(mode_wr), .mode_req(mreq), .cfg_wr(cfg_wr),
        .low_slope_in(low_in), .flash_in(flash), .serial_select_n(ssn),
        .fail_clear(fclr), .wake_clear(wclr), .bus_level_in(bus),
        .bus_drive_out(dout), .bus_drive_oe(oe), .bus_transmit_input(txd),
        .rxd_out(rxd), .supply_uv(uv_in),
        .first_transceiver_mode_field(mode_f),
        .first_transceiver_fail_flag(fail), .bus_wake_flag(wkf),
        .int_n(int_n), .restart_req(rst_q), .main_supply_ramp(ramp),
        .watchdog_enable_req(wd_q), .low_slope_select(low_q),
        .slope_off(soff), .ev_valid(ev_v), .ev_data(ev_d),
        .ev_ready(ev_rdy));
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string nm, input logic [6:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic sel(input int s);
        return s == 0 ? oe : s == 1 ? wkf : low_q;
    endfunction
    // Every wait is bounded; running out ends the run
    task automatic wt(input int s, input logic v);
        int i;
        for (i = 0; i < 64 && sel(s) !== v; i++)
            cyc(1);
        if (i == 64)
        begin
            n_mismatch++;
            $display("[ERR] wait %0d expected %b seen %b", s, v, sel(s));
            wrap_up();
        end
    endtask
    task automatic mwr(input xcvr_mode_t m);
        mreq = m;
        mode_wr = 1;
        cyc(1);
        mode_wr = 0;
        cyc(1);
    endtask
    // Dominant for 3800 cycles, just past the 3750-cycle wake filter, then recessive
    task automatic wake_pat();
        rdom = 1;
        cyc(3800);
        rdom = 0;
    endtask
    task automatic slope(input logic v);
        low_in = v;
        cfg_wr = 1;
        cyc(1);
        cfg_wr = 0;
        ssn = 0;
        cyc(3);
        ssn = 1;
        cyc(8);
    endtask
    task automatic t_off();
        chk("mode", {5'h0, XM_OFF}, {5'h0, mode_f});
        chk("rxd", 7'h1, {6'h0, rxd});
        wake_pat();
        cyc(20);
        chk("wake", 7'h0, {6'h0, wkf});
        $display("done off");
    endtask
    task automatic t_normal();
        txd = 0;
        mwr(XM_NORMAL);
        chk("mode", {5'h0, XM_NORMAL}, {5'h0, mode_f});
        cyc(4);
        chk("early oe", 7'h0, {6'h0, oe});
        txd = 1;
        cyc(20);
        txd = 0;
        wt(0, 1);
        chk("dout", 7'h0, {6'h0, dout});
        cyc(6);
        chk("rxd dom", 7'h0, {6'h0, rxd});
        cyc(40);
        chk("to oe", 7'h0, {6'h0, oe});
        chk("to fail", 7'h1, {6'h0, fail});
        txd = 1;
        cyc(8);
        fclr = 1;
        cyc(1);
        fclr = 0;
        rdom = 1;
        cyc(40);
        chk("clamp", 7'h1, {6'h0, fail});
        chk("mode", {5'h0, XM_NORMAL}, {5'h0, mode_f});
        mwr(XM_RXONLY);
        txd = 0;
        cyc(10);
        chk("rx oe", 7'h0, {6'h0, oe});
        chk("rx rxd", 7'h0, {6'h0, rxd});
        uv_in = 1;
        cyc(8);
        chk("uv rxd", 7'h1, {6'h0, rxd});
        uv_in = 0;
        cyc(8);
        chk("uv back", 7'h0, {6'h0, rxd});
        rdom = 0;
        txd = 1;
        flash = 1;
        slope(1);
        wt(2, 1);
        chk("flash", 7'h1, {6'h0, soff});
        $display("done normal");
    endtask
    task automatic t_stop();
        sys = SYS_STOP;
        slope(0);
        chk("slope", 7'h1, {6'h0, low_q});
        mwr(XM_OFF);
        mwr(XM_NORMAL);
        chk("mode", {5'h0, XM_OFF}, {5'h0, mode_f});
        mwr(XM_WAKE);
        wd_on = 1;
        ev_rdy = 0;
        sclr = 1;
        cyc(1);
        sclr = 0;
        wake_pat();
        wt(1, 1);
        cyc(3);
        chk("int", 7'h0, {6'h0, int_n});
        chk("rxd", 7'h0, {6'h0, rxd});
        chk("mode", {5'h0, XM_WAKE}, {5'h0, mode_f});
        chk("pulses", 7'h1, {4'h0, seen});
        chk("event", {2'h1, SYS_STOP}, ev_d);
        ev_rdy = 1;
        wclr = 1;
        cyc(1);
        wclr = 0;
        cyc(2);
        chk("drain", 7'h0, {6'h0, ev_v});
        wake_pat();
        cyc(20);
        chk("disarmed", 7'h0, {6'h0, wkf});
        mwr(XM_OFF);
        cyc(3);
        chk("rxd rel", 7'h1, {6'h0, rxd});
        mwr(XM_WAKE);
        wd_en = 1;
        sclr = 1;
        cyc(1);
        sclr = 0;
        wake_pat();
        wt(1, 1);
        cyc(3);
        chk("wd gated", 7'h0, {4'h0, seen});
        $display("done stop");
    endtask
    task automatic t_sleep();
        sys = SYS_SLEEP;
        wclr = 1;
        sclr = 1;
        cyc(1);
        wclr = 0;
        sclr = 0;
        cyc(2);
        wake_pat();
        wt(1, 1);
        cyc(3);
        chk("int", 7'h1, {6'h0, int_n});
        chk("pulses", 7'h6, {4'h0, seen});
        chk("rxd", 7'h0, {6'h0, rxd});
        $display("done sleep");
    endtask
    task automatic t_fail();
        mwr(XM_OFF);
        sys = SYS_FAILSAFE;
        wclr = 1;
        sclr = 1;
        cyc(1);
        wclr = 0;
        sclr = 0;
        cyc(2);
        chk("fs mode", {5'h0, XM_WAKE}, {5'h0, mode_f});
        wake_pat();
        wt(1, 1);
        cyc(3);
        chk("fs int", 7'h1, {6'h0, int_n});
        chk("fs pulses", 7'h6, {4'h0, seen});
        chk("fs rxd", 7'h0, {6'h0, rxd});
        $display("done fail-safe");
    endtask
    task automatic wrap_up();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        cyc(10);
        rst_b = 1;
        cyc(2);
        t_off();
        t_normal();
        t_stop();
        t_sleep();
        t_fail();
        wrap_up();
    end
endmodule
`default_nettype wire
